// ### lpcfg_top.v
// Purpose: Register file and mode decode for loop A of a clock translator
// Assumes: Host register port on clk; reference fail flags on pins
// Notes:   Loop A datapath lies outside; this block drives its settings
// Overview of operation
// - Register 0x0EF holds pairing nibbles for references six and seven.
// - Register 0x0F0 holds pairing nibbles for references eight and nine.
// - Register 0x0F1 holds reference ten pairing; upper bits stay at reset.
// - Own number means no sync; 0x0-0xA name sync ref; others reserved.
// - Locked to paired reference, align outputs to the paired frame pulse.
// - Page register value selects the page for serial register accesses.
// - Control bits 7:5 choose loop filter corner, 14 Hz to 5.2 Hz.
// - Control bit 4 realigns outputs to the configured reset phase position.
// - Control bits 3:2 choose phase slope limit or unlimited.
// - Slope limit is not strict; transients may exceed it.
// - Capture range bits 2:0 select pull-in range; 101 and 110 reserved.
// - Mode bits 2:0 select freerun, holdover, forced, auto or NCO.
// - Forced mode locks loop A to the reference in mode bits 7:4.
// - Forced reference failure sends loop A into holdover, no switching.
// - Forced reference field is ignored outside forced mode.
`timescale 1ns/10ps
module lpcfg_top (
  clk,
  rst,
  reg_addr,
  reg_wr,
  reg_rd,
  reg_wdata,
  reg_rdata,
  ref_fail,
  auto_ref,
  page_sel,
  bw_code,
  psl_code,
  realign_clear,
  range_code,
  eff_mode,
  lock_ref,
  lock_ref_valid,
  align_sync_en,
  align_sync_ref,
  cfg_error
);
  input  wire        clk;
  input  wire        rst;
  input  wire [8:0]  reg_addr;
  input  wire        reg_wr;
  input  wire        reg_rd;
  input  wire [7:0]  reg_wdata;
  output reg  [7:0]  reg_rdata;
  input  wire [10:0] ref_fail;
  input  wire [3:0]  auto_ref;
  output wire [7:0]  page_sel;
  output wire [2:0]  bw_code;
  output wire [1:0]  psl_code;
  output wire        realign_clear;
  output wire [2:0]  range_code;
  output reg  [2:0]  eff_mode;
  output reg  [3:0]  lock_ref;
  output reg         lock_ref_valid;
  output reg         align_sync_en;
  output reg  [3:0]  align_sync_ref;
  output reg         cfg_error;
`include "lpcfg_regs.vh"

  reg  [7:0]  pair_7_6_r;
  reg  [7:0]  pair_9_8_r;
  reg  [3:0]  pair_10_r;
  reg  [7:0]  page_r;
  reg  [7:0]  ctrl_r;
  reg  [7:0]  range_r;
  reg  [7:0]  mode_r;
  reg  [10:0] fail_s1_r;
  reg  [10:0] fail_s2_r;
  reg  [3:0]  auto_s1_r;
  reg  [3:0]  auto_s2_r;
  reg  [3:0]  auto_s3_r;
  reg  [3:0]  auto_sel_r;
  reg  [7:0]  rdata_nxt;
  reg  [2:0]  eff_mode_nxt;
  reg  [3:0]  lock_ref_nxt;
  reg         lock_valid_nxt;
  reg  [3:0]  sel_code;
  reg  [3:0]  pair_nib;
  wire        pd_has_sync;
  wire [3:0]  pd_sync_ref;
  wire        pd_bad;
  wire [2:0]  mode_code;
  wire [3:0]  forced_ref;
  wire        range_bad;
  wire        mode_bad;
  // Reset values sliced where reserved bits are rebuilt
  localparam [7:0] RST_P10  = `LPCFG_RST_PAIR_10;
  localparam [7:0] RST_CTRL = `LPCFG_RST_CTRL;

  // Reference index in range 0..10
  function ref_ok;
    input [3:0] r;
    begin
      ref_ok = (r <= `LPCFG_PAIR_MAX);
    end
  endfunction

  // Write strobe for one register offset
  function wr_hit;
    input       wr;
    input [8:0] addr;
    input [8:0] off;
    begin
      wr_hit = wr && (addr == off);
    end
  endfunction

  // Host writes, one block per register
  // Pairing nibbles, references six and seven
  always @(posedge clk) begin
    if (rst) begin
      pair_7_6_r <= `LPCFG_RST_PAIR_7_6;
    end else if (wr_hit(reg_wr, reg_addr, `LPCFG_OFF_PAIR_7_6)) begin
      pair_7_6_r <= reg_wdata;
    end
  end

  // Pairing nibbles, references eight and nine
  always @(posedge clk) begin
    if (rst) begin
      pair_9_8_r <= `LPCFG_RST_PAIR_9_8;
    end else if (wr_hit(reg_wr, reg_addr, `LPCFG_OFF_PAIR_9_8)) begin
      pair_9_8_r <= reg_wdata;
    end
  end

  // Pairing nibble, reference ten; reserved upper bits not stored
  always @(posedge clk) begin
    if (rst) begin
      pair_10_r <= RST_P10[3:0];
    end else if (wr_hit(reg_wr, reg_addr, `LPCFG_OFF_PAIR_10)) begin
      pair_10_r <= reg_wdata[3:0];
    end
  end

  // Serial page
  always @(posedge clk) begin
    if (rst) begin
      page_r <= `LPCFG_RST_PAGE;
    end else if (wr_hit(reg_wr, reg_addr, `LPCFG_OFF_PAGE)) begin
      page_r <= reg_wdata;
    end
  end

  // Loop control; reserved low bits keep reset value
  always @(posedge clk) begin
    if (rst) begin
      ctrl_r <= `LPCFG_RST_CTRL;
    end else if (wr_hit(reg_wr, reg_addr, `LPCFG_OFF_CTRL)) begin
      ctrl_r <= {reg_wdata[7:2], RST_CTRL[1:0]};
    end
  end

  // Capture range; reserved upper bits stay zero
  always @(posedge clk) begin
    if (rst) begin
      range_r <= `LPCFG_RST_RANGE;
    end else if (wr_hit(reg_wr, reg_addr, `LPCFG_OFF_RANGE)) begin
      range_r <= {5'h00, reg_wdata[2:0]};
    end
  end

  // Mode and forced reference; bit 3 reserved
  always @(posedge clk) begin
    if (rst) begin
      mode_r <= `LPCFG_RST_MODE;
    end else if (wr_hit(reg_wr, reg_addr, `LPCFG_OFF_MODE)) begin
      mode_r <= {reg_wdata[7:4], 1'b0, reg_wdata[2:0]};
    end
  end

  // Read mux; unmapped offsets read zero
  always @* begin
    case (reg_addr)
      `LPCFG_OFF_PAIR_7_6: rdata_nxt = pair_7_6_r;
      `LPCFG_OFF_PAIR_9_8: rdata_nxt = pair_9_8_r;
      `LPCFG_OFF_PAIR_10:  rdata_nxt = {RST_P10[7:4], pair_10_r};
      `LPCFG_OFF_PAGE:     rdata_nxt = page_r;
      `LPCFG_OFF_CTRL:     rdata_nxt = ctrl_r;
      `LPCFG_OFF_RANGE:    rdata_nxt = range_r;
      `LPCFG_OFF_MODE:     rdata_nxt = mode_r;
      default:             rdata_nxt = 8'h00;
    endcase
  end

  // Read data held until the next read
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end
  end

  // Fail flags come from outside the clock domain
  always @(posedge clk) begin
    if (rst) begin
      fail_s1_r <= 11'h000;
      fail_s2_r <= 11'h000;
    end else begin
      fail_s1_r <= ref_fail;
      fail_s2_r <= fail_s1_r;
    end
  end

  // Selector word synchronised, then taken once two samples agree
  always @(posedge clk) begin
    if (rst) begin
      auto_s1_r <= 4'h0;
      auto_s2_r <= 4'h0;
      auto_s3_r <= 4'h0;
    end else begin
      auto_s1_r <= auto_ref;
      auto_s2_r <= auto_s1_r;
      auto_s3_r <= auto_s2_r;
    end
  end

  // Skewed bits of a changing word never reach the loop
  always @(posedge clk) begin
    if (rst) begin
      auto_sel_r <= 4'h0;
    end else if (auto_s2_r == auto_s3_r) begin
      auto_sel_r <= auto_s2_r;
    end
  end

  assign page_sel      = page_r;
  assign bw_code       = ctrl_r[`LPCFG_CTRL_BW_HI:`LPCFG_CTRL_BW_LO];
  assign realign_clear = ctrl_r[`LPCFG_CTRL_REALIGN];
  // Slope limit is a target only; loop may overshoot it
  assign psl_code      = ctrl_r[`LPCFG_CTRL_PSL_HI:`LPCFG_CTRL_PSL_LO];
  assign range_code    = range_r[2:0];
  assign mode_code     = mode_r[`LPCFG_MODE_HI:`LPCFG_MODE_LO];
  assign forced_ref    = mode_r[`LPCFG_MODE_REF_HI:`LPCFG_MODE_REF_LO];
  assign range_bad     = (range_code == 3'h5) || (range_code == 3'h6);
  assign mode_bad      = (mode_code > `LPCFG_MODE_NCO);

  // Mode decode and reference choice
  always @* begin
    eff_mode_nxt   = mode_code;
    lock_ref_nxt   = 4'h0;
    lock_valid_nxt = 1'b0;
    case (mode_code)
      `LPCFG_MODE_FORCED: begin
        // Forced field only read here
        if (!ref_ok(forced_ref) || fail_s2_r[forced_ref]) begin
          eff_mode_nxt = `LPCFG_MODE_HOLDOVER;
        end else begin
          lock_ref_nxt   = forced_ref;
          lock_valid_nxt = 1'b1;
        end
      end
      `LPCFG_MODE_AUTO: begin
        if (ref_ok(auto_sel_r)) begin
          lock_ref_nxt   = auto_sel_r;
          lock_valid_nxt = 1'b1;
        end
      end
      `LPCFG_MODE_FREERUN, `LPCFG_MODE_HOLDOVER, `LPCFG_MODE_NCO: begin
        eff_mode_nxt = mode_code;
      end
      default: begin
        eff_mode_nxt = `LPCFG_MODE_FREERUN;
      end
    endcase
  end

  // Pairing nibble of the locked reference
  always @* begin
    sel_code = lock_ref_nxt;
    case (sel_code)
      4'h6:    pair_nib = pair_7_6_r[3:0];
      4'h7:    pair_nib = pair_7_6_r[7:4];
      4'h8:    pair_nib = pair_9_8_r[3:0];
      4'h9:    pair_nib = pair_9_8_r[7:4];
      4'hA:    pair_nib = pair_10_r;
      default: pair_nib = sel_code;
    endcase
  end

  lpcfg_pair_decode u_pair (
    .pair_code (pair_nib),
    .own_ref   (sel_code),
    .has_sync  (pd_has_sync),
    .sync_ref  (pd_sync_ref),
    .code_bad  (pd_bad)
  );

  always @(posedge clk) begin
    if (rst) begin
      eff_mode       <= `LPCFG_MODE_AUTO;
      lock_ref       <= 4'h0;
      lock_ref_valid <= 1'b0;
      align_sync_en  <= 1'b0;
      align_sync_ref <= 4'h0;
      cfg_error      <= 1'b0;
    end else begin
      eff_mode       <= eff_mode_nxt;
      lock_ref       <= lock_ref_nxt;
      lock_ref_valid <= lock_valid_nxt;
      // Lock stays on clock ref, phase follows paired frame pulse
      align_sync_en  <= lock_valid_nxt && pd_has_sync;
      align_sync_ref <= pd_sync_ref;
      // Reserved codes flagged for the host
      cfg_error      <= range_bad || mode_bad || (lock_valid_nxt && pd_bad);
    end
  end
endmodule

// ### lpcfg_regs.vh
// Purpose: Offsets, fields, reset values and codes of the loop A config block
// Assumes: 9-bit register address, 8-bit data
// Notes:   Definitions only
`ifndef LPCFG_REGS_VH
`define LPCFG_REGS_VH
`define LPCFG_OFF_PAIR_7_6    9'h0EF
`define LPCFG_OFF_PAIR_9_8    9'h0F0
`define LPCFG_OFF_PAIR_10     9'h0F1
`define LPCFG_OFF_PAGE        9'h0FF
`define LPCFG_OFF_CTRL        9'h100
`define LPCFG_OFF_RANGE       9'h102
`define LPCFG_OFF_MODE        9'h103
`define LPCFG_RST_PAIR_7_6    8'h76
`define LPCFG_RST_PAIR_9_8    8'h98
`define LPCFG_RST_PAIR_10     8'h0A
`define LPCFG_RST_PAGE        8'h00
`define LPCFG_RST_CTRL        8'h0C
`define LPCFG_RST_RANGE       8'h00
`define LPCFG_RST_MODE        8'h03
`define LPCFG_CTRL_BW_HI      7
`define LPCFG_CTRL_BW_LO      5
`define LPCFG_CTRL_REALIGN    4
`define LPCFG_CTRL_PSL_HI     3
`define LPCFG_CTRL_PSL_LO     2
`define LPCFG_MODE_REF_HI     7
`define LPCFG_MODE_REF_LO     4
`define LPCFG_MODE_HI         2
`define LPCFG_MODE_LO         0
`define LPCFG_MODE_FREERUN    3'h0
`define LPCFG_MODE_HOLDOVER   3'h1
`define LPCFG_MODE_FORCED     3'h2
`define LPCFG_MODE_AUTO       3'h3
`define LPCFG_MODE_NCO        3'h4
`define LPCFG_PAIR_MAX        4'hA
`define LPCFG_NUM_REFS        11
`endif

// ### lpcfg_pair_decode.v
// Purpose: Decodes one reference's sync pairing nibble
// Assumes: Nibble and own reference number are same-clock values
// Notes:   Combinational
`timescale 1ns/10ps
module lpcfg_pair_decode (
  pair_code,
  own_ref,
  has_sync,
  sync_ref,
  code_bad
);
  input  wire [3:0] pair_code;
  input  wire [3:0] own_ref;
  output wire       has_sync;
  output wire [3:0] sync_ref;
  output wire       code_bad;
`include "lpcfg_regs.vh"
  // Own number means no sync; 0xB to 0xF are not valid references
  assign code_bad = (pair_code > `LPCFG_PAIR_MAX);
  assign has_sync = (pair_code != own_ref) && !code_bad;
  assign sync_ref = has_sync ? pair_code : own_ref;
endmodule

// ### lpcfg_src.sv
// Purpose: Reference source model for loop A
// Assumes: Bench sets fail and selector levels
// Notes:   Levels change just after clk
`timescale 1ns/10ps
module lpcfg_src (
  input  wire        clk,
  input  wire [10:0] fail_req,
  input  wire [3:0]  sel_req,
  output reg  [10:0] ref_fail = 11'h000,
  output reg  [3:0]  auto_ref = 4'h0
);
  always @(posedge clk) begin
    ref_fail <= fail_req;
    auto_ref <= sel_req;
  end
endmodule

// ### lpcfg_chk.sv
// Purpose: Port checks for loop A config block
// Assumes: One clk domain, rst sync high
// Notes:   Bound to lpcfg_top
`timescale 1ns/10ps
module lpcfg_chk (
  input wire        clk,
  input wire        rst,
  input wire [8:0]  reg_addr,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_wdata,
  input wire [7:0]  reg_rdata,
  input wire [10:0] ref_fail,
  input wire [7:0]  page_sel,
  input wire [2:0]  bw_code,
  input wire [1:0]  psl_code,
  input wire        realign_clear,
  input wire [2:0]  range_code,
  input wire [2:0]  eff_mode,
  input wire [3:0]  lock_ref,
  input wire        lock_ref_valid,
  input wire        cfg_error
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_mode_wr;
    reg_wr && reg_addr == 9'h103 ##1 !reg_wr;
  endsequence
  sequence s_forced;
    reg_wr && reg_addr == 9'h103 && reg_wdata[2:0] == 3'h2 && reg_wdata[7:4] <= 4'hA
      && ref_fail == 11'h000 && $past(ref_fail) == 11'h000 ##1 !reg_wr;
  endsequence
  ctrl_map_a:
    assert property (reg_wr && reg_addr == 9'h100 |=> {bw_code, realign_clear, psl_code}
      == $past(reg_wdata[7:2])) else $error("ctrl fields wrong");
  page_map_a:
    assert property (reg_wr && reg_addr == 9'h0FF |=> page_sel == $past(reg_wdata))
      else $error("page wrong");
  range_map_a:
    assert property (reg_wr && reg_addr == 9'h102 |=> range_code == $past(reg_wdata[2:0]))
      else $error("range wrong");
  page_read_a:
    assert property (reg_rd && reg_addr == 9'h0FF |=> reg_rdata == $past(page_sel))
      else $error("page read wrong");
  hole_read_a: assert property (reg_rd && reg_addr == 9'h101 |=> reg_rdata == 8'h00)
    else $error("hole read not zero");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
  mode_plain_a:
    assert property (s_mode_wr |=> $past(reg_wdata[2:0], 2) inside {3'h0, 3'h1, 3'h3, 3'h4}
      -> eff_mode == $past(reg_wdata[2:0], 2)) else $error("mode decode wrong");
  mode_rsvd_a:
    assert property (s_mode_wr |=> $past(reg_wdata[2:0], 2) > 3'h4
      -> eff_mode == 3'h0 && cfg_error) else $error("reserved mode wrong");
  forced_lock_a:
    assert property (s_forced |=> eff_mode == 3'h2 && lock_ref_valid
      && lock_ref == $past(reg_wdata[7:4], 2)) else $error("forced lock wrong");
  fail_hold_a:
    assert property ((eff_mode == 3'h2 && ref_fail[lock_ref] && !reg_wr)[*3]
      |=> eff_mode == 3'h1) else $error("no holdover on fail");
endmodule
bind lpcfg_top lpcfg_chk u_lpcfg_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .ref_fail(ref_fail), .page_sel(page_sel), .bw_code(bw_code), .psl_code(psl_code),
  .realign_clear(realign_clear), .range_code(range_code), .eff_mode(eff_mode),
  .lock_ref(lock_ref), .lock_ref_valid(lock_ref_valid), .cfg_error(cfg_error));

// ### lpcfg_top_test.sv
// Purpose: Self-checking bench for loop A config block
// Assumes: Register port on clk, model in bench
// Notes:   Random data from a fixed seed
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module lpcfg_top_test;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [8:0]  reg_addr = 9'h000;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg  [7:0]  reg_wdata = 8'h00;
  reg  [10:0] fail_req = 11'h000;
  reg  [3:0]  sel_req = 4'h0;
  wire [7:0]  reg_rdata, page_sel;
  wire [10:0] ref_fail;
  wire [3:0]  auto_ref, lock_ref, align_sync_ref;
  wire [2:0]  bw_code, range_code, eff_mode;
  wire [1:0]  psl_code;
  wire        realign_clear, lock_ref_valid, align_sync_en, cfg_error;
  int         failures = 0;
  int         tests_run = 0;
  int         m[int];
  int         a, d, r, n, i;
  int         adr[7] = '{9'h0EF, 9'h0F0, 9'h0F1, 9'h0FF, 9'h100, 9'h102, 9'h103};
  int         rv[7] = '{8'h76, 8'h98, 8'h0A, 8'h00, 8'h0C, 8'h00, 8'h03};
  always #5 clk = ~clk;
  lpcfg_src u_lpcfg_src (.clk(clk), .fail_req(fail_req), .sel_req(sel_req),
    .ref_fail(ref_fail), .auto_ref(auto_ref));
  lpcfg_top u_lpcfg_top (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ref_fail(ref_fail),
    .auto_ref(auto_ref), .page_sel(page_sel), .bw_code(bw_code), .psl_code(psl_code),
    .realign_clear(realign_clear), .range_code(range_code), .eff_mode(eff_mode),
    .lock_ref(lock_ref), .lock_ref_valid(lock_ref_valid), .align_sync_en(align_sync_en),
    .align_sync_ref(align_sync_ref), .cfg_error(cfg_error));
  function automatic int msk(int x);
    return x == 9'h0F1 ? 8'h0F : x == 9'h100 ? 8'hFC : x == 9'h102 ? 8'h07 :
      x == 9'h103 ? 8'hF7 : 8'hFF;
  endfunction
  task automatic wr(int x, int v);
    @(posedge clk);
    reg_addr  <= x[8:0];
    reg_wdata <= v[7:0];
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    if (m.exists(x)) m[x] = v & msk(x);
  endtask
  task automatic rd(int x);
    @(posedge clk);
    reg_addr <= x[8:0];
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    `CHK(reg_rdata, m.exists(x) ? m[x][7:0] : 8'h00)
  endtask
  task automatic outs();
    `CHK(page_sel, m[9'h0FF][7:0])
    `CHK({bw_code, realign_clear, psl_code}, m[9'h100][7:2])
    `CHK(range_code, m[9'h102][2:0])
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    close_out();
  end
  initial begin
    d = $urandom(32'h9602);
    foreach (adr[k]) m[adr[k]] = rv[k];
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    foreach (adr[k]) rd(adr[k]);
    rd(9'h101);
    outs();
    $display("test 1 done");
    for (i = 0; i < 40; i++) begin
      a = i % 8 < 7 ? adr[i % 8] : 9'h101;
      wr(a, $urandom);
      rd(a);
      outs();
    end
    $display("test 2 done");
    for (i = 0; i < 8; i++) begin
      r = $urandom_range(10, 0);
      wr(9'h103, r * 16 + i);
      repeat (2) @(negedge clk);
      `CHK(eff_mode, i == 2 ? 3'h2 : i > 4 ? 3'h0 : i[2:0])
      if (i == 2) `CHK({lock_ref_valid, lock_ref}, {1'b1, r[3:0]})
    end
    $display("test 3 done");
    wr(9'h100, 8'h0C);
    wr(9'h102, 0);
    for (r = 6; r < 11; r++) begin
      n = r == 7 ? 7 : r == 10 ? 11 : $urandom_range(10, 0);
      a = r < 8 ? 9'h0EF : r < 10 ? 9'h0F0 : 9'h0F1;
      d = r % 2 ? (m[a] & 8'h0F) | n * 16 : (m[a] & 8'hF0) | n;
      wr(a, d);
      wr(9'h103, r * 16 + 2);
      repeat (2) @(negedge clk);
      `CHK({align_sync_en, cfg_error}, {n != r && n < 11, n > 10})
      if (n != r && n < 11) `CHK(align_sync_ref, n[3:0])
    end
    $display("test 4 done");
    wr(9'h103, 8'h52);
    fail_req <= 11'h020;
    repeat (6) @(negedge clk);
    `CHK(eff_mode, 3'h1)
    @(posedge clk);
    fail_req <= 11'h000;
    sel_req  <= 4'h9;
    wr(9'h103, 8'hA3);
    repeat (6) @(negedge clk);
    `CHK({eff_mode, lock_ref_valid, lock_ref}, {3'h3, 1'b1, 4'h9})
    `CHK(cfg_error, 1'b0)
    wr(9'h102, 6);
    repeat (2) @(negedge clk);
    `CHK({range_code, cfg_error}, 4'hD)
    $display("test 5 done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    foreach (adr[k]) m[adr[k]] = rv[k];
    foreach (adr[k]) rd(adr[k]);
    outs();
    `CHK({eff_mode, cfg_error}, 4'h6)
    $display("test 6 done");
    close_out();
  end
endmodule
